// ==== rtl/tpm_pkg.sv ====
/*
  Constants shared by the one pulse timer and its prescaler: register
  indices, field positions, reset values, bus encodings and divider ratios.
  Assumes a 32-bit AHB-Lite bus and 8-bit timer registers in the low byte lane.
*/
package tpm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address of each is four times its index
  localparam logic [7:0] IDX_CR2   = 8'h51;
  localparam logic [7:0] IDX_CR1   = 8'h52;
  localparam logic [7:0] IDX_CSR   = 8'h53;
  localparam logic [7:0] IDX_IC1HR = 8'h54;
  localparam logic [7:0] IDX_IC1LR = 8'h55;
  localparam logic [7:0] IDX_OC1HR = 8'h56;
  localparam logic [7:0] IDX_OC1LR = 8'h57;
  localparam logic [7:0] IDX_CHR   = 8'h58;
  localparam logic [7:0] IDX_CLR   = 8'h59;
  localparam logic [7:0] IDX_ALTERNATE_COUNTER_HIGH_BYTE  = 8'h5A;
  localparam logic [7:0] IDX_ALTERNATE_COUNTER_LOW_BYTE  = 8'h5B;
  localparam logic [7:0] IDX_SECOND_CAPTURE_HIGH_BYTE = 8'h5C;
  localparam logic [7:0] IDX_SECOND_CAPTURE_LOW_BYTE = 8'h5D;
  localparam logic [7:0] IDX_SECOND_COMPARE_HIGH_BYTE = 8'h5E;
  localparam logic [7:0] IDX_SECOND_COMPARE_LOW_BYTE = 8'h5F;
  localparam logic [7:0] IDX_ISTAT = 8'h60;
  localparam logic [7:0] IDX_IMASK = 8'h61;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of the second and first control registers
  localparam int unsigned CR2_FIRST_COMPARE_OUTPUT_ENABLE  = 7;
  localparam int unsigned CR2_OC2E  = 6;
  localparam int unsigned CR2_OPM   = 5;
  localparam int unsigned CR2_PWM   = 4;
  localparam int unsigned CR2_CC_HI = 3;
  localparam int unsigned CR2_CC_LO = 2;
  localparam int unsigned CR2_IEDG2 = 1;
  localparam int unsigned CR1_CAPTURE_INTERRUPT_ENABLE  = 7;
  localparam int unsigned CR1_OCIE  = 6;
  localparam int unsigned CR1_TOIE  = 5;
  localparam int unsigned CR1_DURING_PULSE_LEVEL = 2;
  localparam int unsigned CR1_FIRST_EDGE_SELECT = 1;
  localparam int unsigned CR1_AFTER_PULSE_LEVEL = 0;

  // Status flags sit in bits 7:3; the same layout serves status and mask
  localparam int unsigned NFLAG     = 5;
  localparam int unsigned FLAG_LO   = 3;
  localparam int unsigned CSR_TIMD  = 2;
  localparam int unsigned FL_FIRST_CAPTURE_FLAG   = 4;
  localparam int unsigned FL_FIRST_COMPARE_FLAG   = 3;
  localparam int unsigned FL_TOF    = 2;
  localparam int unsigned FL_SECOND_CAPTURE_FLAG   = 1;
  localparam int unsigned FL_SECOND_COMPARE_FLAG   = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and load values
  localparam logic [7:0]  REG_RST     = 8'h00;
  localparam logic [7:0]  IMASK_RST   = 8'hF8;
  localparam logic [15:0] CNT_RST     = 16'hFFFC;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] OPM_START   = 16'h00FC;
  localparam logic [15:0] OPM_CAPTURE = 16'hFFFD;
  localparam logic [15:0] WORD_RST    = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and prescaler
  localparam int unsigned CLK_HZ      = 10000000;
  localparam int unsigned CLK_NS      = 100;
  localparam int unsigned PRESCALE_FACTOR_W     = 13;
  localparam int unsigned DIV_CC00    = 4;
  localparam int unsigned DIV_CC01    = 2;
  localparam int unsigned DIV_CC10    = 8;
  localparam int unsigned DIV_LONG    = 8000;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite encodings
  localparam int unsigned IDX_LO      = 2;
  localparam int unsigned IDX_HI      = 9;
  localparam logic        HRESP_OKAY  = 1'b0;

endpackage

// ==== rtl/tpm_prescaler.sv ====
/*
  Timer clock prescaler: turns the bus clock into a one-cycle count enable
  at one of four ratios chosen by the clock select field.
  Assumes a single clock; the long ratio is a parameter so benches can shrink it.
*/
`timescale 1ns/1ps
module tpm_prescaler #(
  parameter int unsigned LONG_DIV = tpm_pkg::DIV_LONG
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Ratio select
  input  wire logic [1:0] clock_select_field,
  // Count enable, one cycle wide
  output logic            tick_ff
);

  logic [tpm_pkg::PRESCALE_FACTOR_W-1:0] div_cnt_ff;
  logic [tpm_pkg::PRESCALE_FACTOR_W-1:0] last_cnt;

  // Terminal count of the selected ratio
  always_comb begin
    case (clock_select_field)
      2'h0:    last_cnt = tpm_pkg::PRESCALE_FACTOR_W'(tpm_pkg::DIV_CC00 - 1);
      2'h1:    last_cnt = tpm_pkg::PRESCALE_FACTOR_W'(tpm_pkg::DIV_CC01 - 1);
      2'h2:    last_cnt = tpm_pkg::PRESCALE_FACTOR_W'(tpm_pkg::DIV_CC10 - 1);
      default: last_cnt = tpm_pkg::PRESCALE_FACTOR_W'(LONG_DIV - 1);
    endcase
  end

  // Divider; a ratio change lands on a short count at worst, never a hang
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_ff <= '0;
      tick_ff    <= 1'b0;
    end else if (div_cnt_ff >= last_cnt) begin
      div_cnt_ff <= '0;
      tick_ff    <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 1'b1;
      tick_ff    <= 1'b0;
    end
  end

endmodule

// ==== rtl/tpm_timer.sv ====
/*
  Sixteen-bit timer with one pulse, pulse width and plain compare/capture
  operation, reached over an AHB-Lite slave port with a level interrupt.
  Assumes trigger and capture pins already synchronous to hclk.
*/
// What this block does
// - One pulse runs only with select bit set
// - Trigger from capture one, end from compare one
// - Trigger loads counter, level, flag and capture
// - Capture flag raises interrupt when enabled
// - Flag clears after status read then low access
// - Compare one match drives after-pulse level
// - No compare one flag; compare two still works
// - Pulse width modulation wins over one pulse
// - Equal levels give constant output
// - Capture one edges restart; capture two captures
// - Compare two flags only, no waveform
// - Output enable hands pin to compare one
// - Edge select picks trigger polarity
`timescale 1ns/1ps
module tpm_timer #(
  parameter int unsigned LONG_DIV = tpm_pkg::DIV_LONG
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Timer pins
  input  wire logic        trigger_input,
  input  wire logic        second_capture_input,
  output logic             pulse_output,
  output logic             second_compare_output,
  // Interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0]  cr2_ff, cr1_ff, istat_ff, imask_ff;
  logic        timd_ff;
  logic [15:0] cnt_ff, ic1_ff, ic2_ff, oc1_ff, oc2_ff;
  logic [tpm_pkg::NFLAG-1:0] fl_ff, arm_ff, ev, lo_acc;
  logic        trig_prev_ff, cap2_prev_ff, eq1_prev_ff, eq2_prev_ff;
  logic        lvl_ff, lvl2_ff;
  logic        hrdata_vld_ff;
  logic [7:0]  rd_byte_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_idx_ff;
  logic        pulse_output_ff, second_compare_output_ff, irq_ff;
  logic        tick;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and pin events
  logic       opm_mode, pwm_mode, norm_mode, edge1, edge2, m1, m2, trig_opm, pwm_wrap;
  logic [1:0] cc_sel;
  assign pwm_mode  = cr2_ff[tpm_pkg::CR2_PWM];
  assign opm_mode  = cr2_ff[tpm_pkg::CR2_OPM] && !pwm_mode;
  assign norm_mode = !opm_mode && !pwm_mode;
  assign cc_sel    = cr2_ff[tpm_pkg::CR2_CC_HI:tpm_pkg::CR2_CC_LO];
  // Edge select turns the chosen transition into a one-cycle event
  assign edge1 = cr1_ff[tpm_pkg::CR1_FIRST_EDGE_SELECT] ? (trigger_input && !trig_prev_ff)
                                            : (!trigger_input && trig_prev_ff);
  assign edge2 = cr2_ff[tpm_pkg::CR2_IEDG2] ? (second_capture_input && !cap2_prev_ff)
                                            : (!second_capture_input && cap2_prev_ff);
  assign trig_opm = opm_mode && edge1;
  // Matches fire once, on the cycle the counter reaches the compare value
  assign m1 = (cnt_ff == oc1_ff) && !eq1_prev_ff;
  assign m2 = (cnt_ff == oc2_ff) && !eq2_prev_ff;
  assign pwm_wrap = pwm_mode && m2;

  // Previous pin levels and match states for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_prev_ff <= 1'b0;
      cap2_prev_ff <= 1'b0;
      eq1_prev_ff  <= 1'b0;
      eq2_prev_ff  <= 1'b0;
    end else begin
      trig_prev_ff <= trigger_input;
      cap2_prev_ff <= second_capture_input;
      eq1_prev_ff  <= (cnt_ff == oc1_ff);
      eq2_prev_ff  <= (cnt_ff == oc2_ff);
    end
  end

  // Prescaler; the compare one value is software's job to size from it
  tpm_prescaler #(
    .LONG_DIV           (LONG_DIV)
  ) u_prescale_factor (
    .hclk               (hclk),
    .hresetn            (hresetn),
    .clock_select_field (cc_sel),
    .tick_ff            (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter: trigger restart beats wrap beats counting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= tpm_pkg::CNT_RST;
    end else if (trig_opm) begin
      cnt_ff <= tpm_pkg::OPM_START;
    end else if (pwm_wrap) begin
      cnt_ff <= tpm_pkg::CNT_RST;
    end else if (tick && !timd_ff) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Capture registers; capture one only loads the fixed value in one pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ic1_ff <= tpm_pkg::WORD_RST;
      ic2_ff <= tpm_pkg::WORD_RST;
    end else begin
      if (trig_opm) begin
        ic1_ff <= tpm_pkg::OPM_CAPTURE;
      end else if (norm_mode && edge1) begin
        ic1_ff <= cnt_ff;
      end
      if (edge2 && !pwm_mode) begin
        ic2_ff <= cnt_ff;
      end
    end
  end

  // Hardware events, one per flag; compare one never flags in one pulse
  always_comb begin
    ev = '0;
    ev[tpm_pkg::FL_FIRST_CAPTURE_FLAG] = edge1 && !pwm_mode;
    ev[tpm_pkg::FL_FIRST_COMPARE_FLAG] = m1 && norm_mode;
    ev[tpm_pkg::FL_TOF]  = tick && !timd_ff && !trig_opm && !pwm_wrap
                           && (cnt_ff == tpm_pkg::CNT_MAX);
    ev[tpm_pkg::FL_SECOND_CAPTURE_FLAG] = edge2 && !pwm_mode;
    ev[tpm_pkg::FL_SECOND_COMPARE_FLAG] = m2 && !pwm_mode;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse and compare levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_ff <= 1'b0;
    end else if (trig_opm) begin
      lvl_ff <= cr1_ff[tpm_pkg::CR1_DURING_PULSE_LEVEL];
    end else if (m1) begin
      lvl_ff <= cr1_ff[tpm_pkg::CR1_AFTER_PULSE_LEVEL];
    end else if (pwm_mode && m2) begin
      lvl_ff <= cr1_ff[tpm_pkg::CR1_DURING_PULSE_LEVEL];
    end
  end

  // Second compare drives its own level only in plain operation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl2_ff <= 1'b0;
    end else if (norm_mode && m2) begin
      lvl2_ff <= cr1_ff[tpm_pkg::CR1_DURING_PULSE_LEVEL];
    end
  end

  // Pins are low while their output enables are off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_output_ff          <= 1'b0;
      second_compare_output_ff <= 1'b0;
    end else begin
      pulse_output_ff          <= cr2_ff[tpm_pkg::CR2_FIRST_COMPARE_OUTPUT_ENABLE] && lvl_ff;
      second_compare_output_ff <= cr2_ff[tpm_pkg::CR2_OC2E] && norm_mode && lvl2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: reads act at the address phase, writes at the data phase
  logic       acc_go, rd_go, mapped;
  logic [7:0] acc_idx;
  assign acc_go  = hsel && hready && htrans[1];
  assign acc_idx = haddr[tpm_pkg::IDX_HI:tpm_pkg::IDX_LO];
  assign mapped  = (haddr[31:tpm_pkg::IDX_HI+1] == '0) && (haddr[1:0] == 2'h0)
                   && (acc_idx >= tpm_pkg::IDX_CR2) && (acc_idx <= tpm_pkg::IDX_IMASK);
  assign rd_go   = acc_go && !hwrite && mapped;

  logic wr_now;
  logic [7:0] wbyte;
  assign wr_now = wr_pend_ff;
  assign wbyte  = hwdata[7:0];

  // Capture the write address for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 8'h00;
    end else if (hready) begin
      wr_pend_ff <= acc_go && hwrite && mapped;
      wr_idx_ff  <= acc_idx;
    end
  end

  // Low byte accesses that complete a flag clear
  logic [7:0] lo_idx [tpm_pkg::NFLAG];
  assign lo_idx[tpm_pkg::FL_FIRST_CAPTURE_FLAG] = tpm_pkg::IDX_IC1LR;
  assign lo_idx[tpm_pkg::FL_FIRST_COMPARE_FLAG] = tpm_pkg::IDX_OC1LR;
  assign lo_idx[tpm_pkg::FL_TOF]  = tpm_pkg::IDX_CLR;
  assign lo_idx[tpm_pkg::FL_SECOND_CAPTURE_FLAG] = tpm_pkg::IDX_SECOND_CAPTURE_LOW_BYTE;
  assign lo_idx[tpm_pkg::FL_SECOND_COMPARE_FLAG] = tpm_pkg::IDX_SECOND_COMPARE_LOW_BYTE;

  // Each flag arms on a status read and clears on its low byte access
  genvar gi;
  generate
    for (gi = 0; gi < tpm_pkg::NFLAG; gi++) begin : g_flag
      assign lo_acc[gi] = (rd_go && acc_idx == lo_idx[gi]) || (wr_now && wr_idx_ff == lo_idx[gi]);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          fl_ff[gi]    <= 1'b0;
          arm_ff[gi]   <= 1'b0;
          istat_ff[gi+tpm_pkg::FLAG_LO] <= 1'b0;
        end else begin
          // A new event wins over a clear in the same cycle
          if (ev[gi]) begin
            fl_ff[gi]  <= 1'b1;
            arm_ff[gi] <= 1'b0;
          end else if (arm_ff[gi] && lo_acc[gi]) begin
            fl_ff[gi]  <= 1'b0;
            arm_ff[gi] <= 1'b0;
          end else if (rd_go && acc_idx == tpm_pkg::IDX_CSR && fl_ff[gi]) begin
            arm_ff[gi] <= 1'b1;
          end
          // Sticky interrupt status, write one to clear, set wins
          if (ev[gi]) begin
            istat_ff[gi+tpm_pkg::FLAG_LO] <= 1'b1;
          end else if (wr_now && wr_idx_ff == tpm_pkg::IDX_ISTAT
                       && wbyte[gi+tpm_pkg::FLAG_LO]) begin
            istat_ff[gi+tpm_pkg::FLAG_LO] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_ff[tpm_pkg::FLAG_LO-1:0] <= '0;
    end else begin
      istat_ff[tpm_pkg::FLAG_LO-1:0] <= '0;
    end
  end

  // Software-written registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cr2_ff   <= tpm_pkg::REG_RST;
      cr1_ff   <= tpm_pkg::REG_RST;
      timd_ff  <= 1'b0;
      oc1_ff   <= tpm_pkg::WORD_RST;
      oc2_ff   <= tpm_pkg::WORD_RST;
      imask_ff <= tpm_pkg::IMASK_RST;
    end else if (wr_now) begin
      case (wr_idx_ff)
        tpm_pkg::IDX_CR2:   cr2_ff <= wbyte;
        tpm_pkg::IDX_CR1:   cr1_ff <= wbyte;
        tpm_pkg::IDX_CSR:   timd_ff <= wbyte[tpm_pkg::CSR_TIMD];
        tpm_pkg::IDX_OC1HR: oc1_ff[15:8] <= wbyte;
        tpm_pkg::IDX_OC1LR: oc1_ff[7:0] <= wbyte;
        tpm_pkg::IDX_SECOND_COMPARE_HIGH_BYTE: oc2_ff[15:8] <= wbyte;
        tpm_pkg::IDX_SECOND_COMPARE_LOW_BYTE: oc2_ff[7:0] <= wbyte;
        tpm_pkg::IDX_IMASK: imask_ff <= wbyte & tpm_pkg::IMASK_RST;
        default: ;
      endcase
    end
  end

  // Read multiplexer; unmapped indices and the spare bits of CSR, ISTAT and IMASK read zero
  logic [7:0] rd_byte;
  always_comb begin
    case (acc_idx)
      tpm_pkg::IDX_CR2:   rd_byte = cr2_ff;
      tpm_pkg::IDX_CR1:   rd_byte = cr1_ff;
      tpm_pkg::IDX_CSR:   rd_byte = {fl_ff, timd_ff, 2'b00};
      tpm_pkg::IDX_IC1HR: rd_byte = ic1_ff[15:8];
      tpm_pkg::IDX_IC1LR: rd_byte = ic1_ff[7:0];
      tpm_pkg::IDX_OC1HR: rd_byte = oc1_ff[15:8];
      tpm_pkg::IDX_OC1LR: rd_byte = oc1_ff[7:0];
      tpm_pkg::IDX_CHR:   rd_byte = cnt_ff[15:8];
      tpm_pkg::IDX_CLR:   rd_byte = cnt_ff[7:0];
      tpm_pkg::IDX_ALTERNATE_COUNTER_HIGH_BYTE:  rd_byte = cnt_ff[15:8];
      tpm_pkg::IDX_ALTERNATE_COUNTER_LOW_BYTE:  rd_byte = cnt_ff[7:0];
      tpm_pkg::IDX_SECOND_CAPTURE_HIGH_BYTE: rd_byte = ic2_ff[15:8];
      tpm_pkg::IDX_SECOND_CAPTURE_LOW_BYTE: rd_byte = ic2_ff[7:0];
      tpm_pkg::IDX_SECOND_COMPARE_HIGH_BYTE: rd_byte = oc2_ff[15:8];
      tpm_pkg::IDX_SECOND_COMPARE_LOW_BYTE: rd_byte = oc2_ff[7:0];
      tpm_pkg::IDX_ISTAT: rd_byte = istat_ff;
      tpm_pkg::IDX_IMASK: rd_byte = imask_ff;
      default:            rd_byte = 8'h00;
    endcase
  end

  // Read data is registered at the address phase, so no wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_byte_ff    <= 8'h00;
      hrdata_vld_ff <= 1'b0;
    end else if (hready) begin
      rd_byte_ff    <= rd_go ? rd_byte : 8'h00;
      hrdata_vld_ff <= rd_go;
    end
  end

  // Interrupt: sticky status gated by mask and by the per-source enables
  logic [7:0] en_vec;
  assign en_vec = {cr1_ff[tpm_pkg::CR1_CAPTURE_INTERRUPT_ENABLE], cr1_ff[tpm_pkg::CR1_OCIE],
                   cr1_ff[tpm_pkg::CR1_TOIE], cr1_ff[tpm_pkg::CR1_CAPTURE_INTERRUPT_ENABLE],
                   cr1_ff[tpm_pkg::CR1_OCIE], 3'b000};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(istat_ff & imask_ff & en_vec);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign hrdata                = {24'h00_0000, rd_byte_ff};
  assign hreadyout             = 1'b1;
  assign hresp                 = tpm_pkg::HRESP_OKAY;
  assign pulse_output          = pulse_output_ff;
  assign second_compare_output = second_compare_output_ff;
  assign irq                   = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  mode_gate_a: assert property (opm_mode |-> cr2_ff[tpm_pkg::CR2_OPM] && !pwm_mode)
    else $error("one pulse active without its select or under pwm");
  pwm_wins_a: assert property (pwm_mode |-> !trig_opm)
    else $error("one pulse restart while pwm selected");
  trig_load_a: assert property (trig_opm |=> cnt_ff == tpm_pkg::OPM_START
                                && ic1_ff == tpm_pkg::OPM_CAPTURE
                                && fl_ff[tpm_pkg::FL_FIRST_CAPTURE_FLAG])
    else $error("trigger did not load counter, capture and flag");
  pulse_start_a: assert property (trig_opm |=> lvl_ff == $past(cr1_ff[tpm_pkg::CR1_DURING_PULSE_LEVEL])
                                  ##1 pulse_output_ff == $past(cr2_ff[tpm_pkg::CR2_FIRST_COMPARE_OUTPUT_ENABLE]
                                  && lvl_ff))
    else $error("pulse level not driven after trigger");
  pulse_end_a: assert property (opm_mode && m1 && !trig_opm
                                |=> lvl_ff == $past(cr1_ff[tpm_pkg::CR1_AFTER_PULSE_LEVEL]))
    else $error("after-pulse level missing at compare match");
  level_hold_a: assert property (opm_mode && !trig_opm && !m1 |=> $stable(lvl_ff))
    else $error("pulse level moved without trigger or match");
  no_first_compare_flag_a: assert property ($rose(fl_ff[tpm_pkg::FL_FIRST_COMPARE_FLAG]) |-> $past(norm_mode))
    else $error("compare one flag set outside plain mode");
  no_wave2_a: assert property (opm_mode [*2] |-> !second_compare_output_ff)
    else $error("second compare waveform during one pulse");
  cap2_load_a: assert property (opm_mode && edge2 |=> fl_ff[tpm_pkg::FL_SECOND_CAPTURE_FLAG]
                                && ic2_ff == $past(cnt_ff))
    else $error("second capture lost in one pulse");
  flag_keep_a: assert property (fl_ff[tpm_pkg::FL_FIRST_CAPTURE_FLAG] && !arm_ff[tpm_pkg::FL_FIRST_CAPTURE_FLAG]
                                |=> fl_ff[tpm_pkg::FL_FIRST_CAPTURE_FLAG])
    else $error("capture flag cleared without status read");
  irq_raise_a: assert property (ev[tpm_pkg::FL_FIRST_CAPTURE_FLAG] && cr1_ff[tpm_pkg::CR1_CAPTURE_INTERRUPT_ENABLE]
                                && imask_ff[tpm_pkg::FL_FIRST_CAPTURE_FLAG+tpm_pkg::FLAG_LO]
                                && $stable(cr1_ff) |-> ##2 irq_ff)
    else $error("capture interrupt not raised");
  count_step_a: assert property (tick && !timd_ff && !trig_opm && !pwm_wrap
                                 |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("counter missed a prescaled tick");
  equal_lvl_a: assert property (opm_mode && lvl_ff == cr1_ff[tpm_pkg::CR1_AFTER_PULSE_LEVEL]
                                && cr1_ff[tpm_pkg::CR1_AFTER_PULSE_LEVEL] == cr1_ff[tpm_pkg::CR1_DURING_PULSE_LEVEL]
                                && $stable(cr1_ff) |=> $stable(lvl_ff))
    else $error("output moved with equal levels");

  trig_seen_c:  cover property (trig_opm ##[1:1000] (opm_mode && m1));
  flag_clear_c: cover property (arm_ff[tpm_pkg::FL_FIRST_CAPTURE_FLAG] ##1 !fl_ff[tpm_pkg::FL_FIRST_CAPTURE_FLAG]);
  irq_seen_c:   cover property ($rose(irq_ff));

endmodule

// ==== testbench/tpm_pin_drv.sv ====
/*
  Far-side model: trigger source and capture-two source for the timer.
  Assumes the caller resumes just after a rising edge of hclk.
*/
`timescale 1ns/1ps
module tpm_pin_drv (
  // Clock
  input  wire logic hclk,
  // Pins towards the timer
  output logic      trigger_input,
  output logic      second_capture_input
);
  // Both lines idle low; levels stay put until the next call
  initial begin
    trigger_input        = 1'b0;
    second_capture_input = 1'b0;
  end
  // Change both pin levels just after an edge so the timer sees a clean step
  task automatic drive(input logic t, input logic c);
    @(posedge hclk);
    trigger_input        <= t;
    second_capture_input <= c;
  endtask
endmodule

// ==== testbench/tpm_timer_one_pulse_mode_tb_top.sv ====
/*
  Bench for the one pulse timer: AHB-Lite register tasks, pin model, checks.
  Assumes zero-wait answers may come but never counts on them.
*/
`timescale 1ns/1ps
module timer_one_pulse_mode_tb_top;
  logic        hclk, hresetn, hsel, hwrite, irq, pulse_output, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic        trigger_input, second_capture_input, second_compare_output;
  int          miscompares, checked, w;
  // Short long-ratio keeps clock select 3 cheap in simulation
  tpm_timer #(.LONG_DIV(16)) tpm_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .trigger_input(trigger_input), .second_capture_input(second_capture_input),
    .pulse_output(pulse_output), .second_compare_output(second_compare_output), .irq(irq));
  tpm_pin_drv tpm_pin_drv_i (.hclk(hclk), .trigger_input(trigger_input),
    .second_capture_input(second_capture_input));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus edge; a stuck hready ends up as a mismatch, not a hang
  task automatic rdy();
    int k;
    for (k = 0; k < 20; k++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    chk(32'h0000_0000, 32'h0000_0001);
    tally_and_finish();
  endtask
  // Single word transfer; byte address is four times the register index
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    rdy();
    d = hrdata;
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0000_0000);
    chk(d, exp);
  endtask
  // Bounded wait for a pin level
  task automatic wait_pin(input logic v);
    int k;
    for (k = 0; k < 64 && pulse_output !== v; k++) @(posedge hclk);
    chk({31'h0, pulse_output}, {31'h0, v});
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    miscompares = 0;
    checked = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    hsel    <= 1'b1;
    // Freeze the counter first so no wrap or compare flag sets before the pulse
    xfer(1'b1, tpm_pkg::IDX_CSR, 32'h0000_0004);
    // Reset values, read-only and unmapped places
    rd(tpm_pkg::IDX_CR2, 32'h0000_0000);
    rd(tpm_pkg::IDX_IMASK, 32'h0000_00F8);
    xfer(1'b1, tpm_pkg::IDX_SECOND_CAPTURE_LOW_BYTE, 32'h0000_00A5);
    rd(tpm_pkg::IDX_SECOND_CAPTURE_LOW_BYTE, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    $display("test registers done");
    // One pulse: compare at 0100h, clock select /2, rising trigger
    xfer(1'b1, tpm_pkg::IDX_OC1HR, 32'h0000_0001);
    xfer(1'b1, tpm_pkg::IDX_OC1LR, 32'h0000_0000);
    xfer(1'b1, tpm_pkg::IDX_CR1, 32'h0000_0086);
    xfer(1'b1, tpm_pkg::IDX_CR2, 32'h0000_00A6);
    xfer(1'b1, tpm_pkg::IDX_CSR, 32'h0000_0000);
    tpm_pin_drv_i.drive(1'b1, 1'b0);
    wait_pin(1'b1);
    tpm_pin_drv_i.drive(1'b0, 1'b1);
    for (w = 1; w < 64 && pulse_output === 1'b1; w++) @(posedge hclk);
    chk({31'h0, w >= 5 && w <= 10}, 32'h0000_0001);
    repeat (20) @(posedge hclk);
    chk({31'h0, pulse_output}, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0001);
    chk({31'h0, second_compare_output}, 32'h0000_0000);
    rd(tpm_pkg::IDX_IC1HR, 32'h0000_00FF);
    rd(tpm_pkg::IDX_CSR, 32'h0000_0090);
    rd(tpm_pkg::IDX_IC1LR, 32'h0000_00FD);
    rd(tpm_pkg::IDX_CSR, 32'h0000_0010);
    $display("test one pulse done");
    // Interrupt mask and write-one-to-clear
    xfer(1'b1, tpm_pkg::IDX_IMASK, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0000_0000);
    xfer(1'b1, tpm_pkg::IDX_IMASK, 32'h0000_00F8);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0000_0001);
    xfer(1'b1, tpm_pkg::IDX_ISTAT, 32'h0000_00F8);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test interrupt done");
    // Equal levels: pin stays high through a whole pulse
    xfer(1'b1, tpm_pkg::IDX_CR1, 32'h0000_0007);
    tpm_pin_drv_i.drive(1'b1, 1'b0);
    wait_pin(1'b1);
    repeat (40) @(posedge hclk);
    chk({31'h0, pulse_output}, 32'h0000_0001);
    $display("test equal levels done");
    tally_and_finish();
  end
endmodule
